/* pkg/dta_demod_cfg_pkg.sv */
// demodulator configuration register slice: offsets, fields, resets, counts
// assumes byte-wide register access from the serial register port engine
package dta_demod_cfg_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] DTA_OFS_RATE = 8'h03;
	localparam logic [7:0] DTA_OFS_LOWER = 8'h04;
	localparam logic [7:0] DTA_OFS_DISCH = 8'h05;
	localparam logic [7:0] DTA_OFS_METHOD = 8'h06;
	localparam logic [7:0] DTA_OFS_AFC = 8'h07;
	localparam logic [7:0] DTA_OFS_FREEZE = 8'h08;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] DTA_RATE_RST = 8'h10;
	localparam logic [7:0] DTA_LOWER_RST = 8'h00;
	localparam logic [7:0] DTA_DISCH_RST = 8'h00;
	localparam logic [7:0] DTA_METHOD_RST = 8'h0F;
	localparam logic [7:0] DTA_AFC_RST = 8'h02;
	localparam logic [7:0] DTA_FREEZE_RST = 8'h00;

	// ----------------------------------------------------------------
	// implemented bits per register, all others read zero
	// ----------------------------------------------------------------
	localparam logic [7:0] DTA_RATE_MASK = 8'hFF;
	localparam logic [7:0] DTA_LOWER_MASK = 8'hFF;
	localparam logic [7:0] DTA_DISCH_MASK = 8'h7F;
	localparam logic [7:0] DTA_METHOD_MASK = 8'h7F;
	localparam logic [7:0] DTA_AFC_MASK = 8'h1F;
	localparam logic [7:0] DTA_FREEZE_MASK = 8'h40;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DTA_LOW_DELAY_BUFFER_SELECT_POS = 7;
	localparam int DTA_LD_BW_POS = 6;
	localparam int DTA_COARSE_LSB = 3;
	localparam int DTA_FINE_LSB = 0;
	localparam int DTA_DT_LSB = 5;
	localparam int DTA_TC_LSB = 0;
	localparam int DTA_METHOD_POS = 6;
	localparam int DTA_BW_POS = 5;
	localparam int DTA_GC_LSB = 0;
	localparam int DTA_LIMIT_LSB = 2;
	localparam int DTA_GAIN_LSB = 0;
	localparam int DTA_FREEZE_POS = 6;

	// ----------------------------------------------------------------
	// codes and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] DTA_COARSE_DEFAULT = 3'h2;
	localparam logic [1:0] DTA_DT_DOUBLE = 2'h1;
	localparam logic [2:0] DTA_LIMIT_OFF = 3'h0;
	localparam logic [3:0] DTA_GAIN_UNIT = 4'h1;
	localparam int DTA_CLK_PERIOD_NS = 10;
	// mclk cycles per fine step at 4x rate, one eighth of the sample period at fine 0
	localparam logic [10:0] DTA_RATE_UNIT = 11'h001;
	localparam int DTA_PERIOD_W = 11;

endpackage : dta_demod_cfg_pkg

/* hw/dta_rate_gen.sv */
// sample-rate enable generator for the demodulator rate converter
// assumes codes come from flops on the same clock
`timescale 1ns/1ps
module dta_rate_gen
	import dta_demod_cfg_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [2:0] coarse_rate_scale_in,
	input wire logic [2:0] fine_rate_scale_in,
	output logic sample_en_out
);

	// ----------------------------------------------------------------
	// period decode: unit * (8+fine) << coarse
	// ----------------------------------------------------------------
	function automatic logic [DTA_PERIOD_W-1:0] rate_period(input logic [2:0] coarse, input logic [2:0] fine);
		logic [DTA_PERIOD_W-1:0] base;
		base = DTA_RATE_UNIT * (11'h008 + {8'h00, fine});
		rate_period = base << coarse;
	endfunction : rate_period

	logic [DTA_PERIOD_W-1:0] cnt;
	wire [DTA_PERIOD_W-1:0] reload_val = rate_period(coarse_rate_scale_in, fine_rate_scale_in) - 11'h001;
	wire cnt_wrap = (cnt == '0);

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt <= '0;
			sample_en_out <= 1'b0;
		end
		else
		begin
			cnt <= cnt_wrap ? reload_val : cnt - 11'h001;
			sample_en_out <= cnt_wrap;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_rate_default: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(cnt_wrap && coarse_rate_scale_in == 3'h2 && fine_rate_scale_in == 3'h0) |=> (cnt == 11'h01F) ##1 sample_en_out == 1'b0)
		else $error("default rate period is not 32 cycles");
	a_rate_slowest: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(cnt_wrap && coarse_rate_scale_in == 3'h7 && fine_rate_scale_in == 3'h0) |=> cnt == 11'h3FF)
		else $error("coarse code 7 is not 1/32 of default");
	a_rate_fast: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(cnt_wrap && coarse_rate_scale_in == 3'h0 && fine_rate_scale_in == 3'h0) |=> cnt == 11'h007)
		else $error("coarse code 0 is not 4x default");
	a_rate_fine: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(cnt_wrap && coarse_rate_scale_in == 3'h2 && fine_rate_scale_in == 3'h7) |=> cnt == 11'h03B)
		else $error("fine code 7 is not 8/15 of default");

endmodule : dta_rate_gen

/* hw/dta_demod_cfg.sv */
// demodulator threshold, rate and frequency-correction configuration registers
// assumes byte register accesses from the serial port engine on mclk_in
`timescale 1ns/1ps
module dta_demod_cfg
	import dta_demod_cfg_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic fsk_mode_in,
	input wire logic preamble_detected_in,
	output logic [7:0] reg_rdata_out,
	output logic sample_en_out,
	output logic [2:0] coarse_rate_scale_out,
	output logic [2:0] fine_rate_scale_out,
	output logic low_delay_buffer_select_out,
	output logic post_filter_wide_out,
	output logic signed [7:0] threshold_lower_bound_out,
	output logic threshold_discharge_double_out,
	output logic [4:0] threshold_time_constant_out,
	output logic precharged_lowpass_en_out,
	output logic threshold_filter_bw_double_out,
	output logic adaptive_peak_detector_en_out,
	output logic [4:0] threshold_gain_param_out,
	output logic freq_correction_en_out,
	output logic [2:0] freq_offset_limit_out,
	output logic [3:0] freq_loop_gain_out,
	output logic freq_loop_update_en_out
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0] rate_cfg;
	logic [7:0] ask_threshold_lower_bound;
	logic [7:0] ask_threshold_discharge_timeconst;
	logic [7:0] ask_threshold_method_gain;
	logic [7:0] freq_correction_config;
	logic [7:0] freeze_cfg;

	wire hit_rate = (reg_addr_in == DTA_OFS_RATE);
	wire hit_lower = (reg_addr_in == DTA_OFS_LOWER);
	wire hit_disch = (reg_addr_in == DTA_OFS_DISCH);
	wire hit_method = (reg_addr_in == DTA_OFS_METHOD);
	wire hit_afc = (reg_addr_in == DTA_OFS_AFC);
	wire hit_freeze = (reg_addr_in == DTA_OFS_FREEZE);

	// unused bits never stored
	wire [7:0] wdata_rate = reg_wdata_in & DTA_RATE_MASK;
	wire [7:0] wdata_lower = reg_wdata_in & DTA_LOWER_MASK;
	wire [7:0] wdata_disch = reg_wdata_in & DTA_DISCH_MASK;
	wire [7:0] wdata_method = reg_wdata_in & DTA_METHOD_MASK;
	wire [7:0] wdata_afc = reg_wdata_in & DTA_AFC_MASK;
	wire [7:0] wdata_freeze = reg_wdata_in & DTA_FREEZE_MASK;

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rate_cfg <= DTA_RATE_RST;
			ask_threshold_lower_bound <= DTA_LOWER_RST;
			ask_threshold_discharge_timeconst <= DTA_DISCH_RST;
			ask_threshold_method_gain <= DTA_METHOD_RST;
			freq_correction_config <= DTA_AFC_RST;
			freeze_cfg <= DTA_FREEZE_RST;
		end
		else if (reg_wr_in)
		begin
			if (hit_rate)
				rate_cfg <= wdata_rate;
			if (hit_lower)
				ask_threshold_lower_bound <= wdata_lower;
			if (hit_disch)
				ask_threshold_discharge_timeconst <= wdata_disch;
			if (hit_method)
				ask_threshold_method_gain <= wdata_method;
			if (hit_afc)
				freq_correction_config <= wdata_afc;
			if (hit_freeze)
				freeze_cfg <= wdata_freeze;
		end
	end

	// ----------------------------------------------------------------
	// read path, unmapped offsets read zero
	// ----------------------------------------------------------------
	wire [7:0] rd_mux = ({8{hit_rate}} & rate_cfg)
		| ({8{hit_lower}} & ask_threshold_lower_bound)
		| ({8{hit_disch}} & ask_threshold_discharge_timeconst)
		| ({8{hit_method}} & ask_threshold_method_gain)
		| ({8{hit_afc}} & freq_correction_config)
		| ({8{hit_freeze}} & freeze_cfg);

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rd_mux;
	end

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	wire [2:0] coarse_code = rate_cfg[DTA_COARSE_LSB +: 3];
	wire [2:0] fine_code = rate_cfg[DTA_FINE_LSB +: 3];
	wire [1:0] disch_code = ask_threshold_discharge_timeconst[DTA_DT_LSB +: 2];
	wire method_peak = ask_threshold_method_gain[DTA_METHOD_POS];
	wire bw_bit = ask_threshold_method_gain[DTA_BW_POS];
	wire [2:0] limit_code = freq_correction_config[DTA_LIMIT_LSB +: 3];
	wire [1:0] gain_code = freq_correction_config[DTA_GAIN_LSB +: 2];
	wire freeze_bit = freeze_cfg[DTA_FREEZE_POS];

	// codes 2 and 3 keep the default discharge time
	wire next_disch_double = (disch_code == DTA_DT_DOUBLE);
	// bandwidth bit only matters for the lowpass method
	wire next_bw_double = ~method_peak & bw_bit;
	wire next_corr_en = (limit_code != DTA_LIMIT_OFF);
	// gain in quarters of default: 1, 2, 4, 8
	wire [3:0] next_gain = DTA_GAIN_UNIT << gain_code;
	// freeze is ignored in ASK mode
	wire freeze_now = freeze_bit & fsk_mode_in & preamble_detected_in;
	wire next_update_en = next_corr_en & ~freeze_now;

	// ----------------------------------------------------------------
	// registered outputs to the datapath
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			coarse_rate_scale_out <= DTA_COARSE_DEFAULT;
			fine_rate_scale_out <= 3'h0;
			low_delay_buffer_select_out <= 1'b0;
			post_filter_wide_out <= 1'b0;
			threshold_lower_bound_out <= 8'sh00;
			threshold_discharge_double_out <= 1'b0;
			threshold_time_constant_out <= 5'h00;
			precharged_lowpass_en_out <= 1'b1;
			threshold_filter_bw_double_out <= 1'b0;
			adaptive_peak_detector_en_out <= 1'b0;
			threshold_gain_param_out <= 5'h0F;
			freq_correction_en_out <= 1'b0;
			freq_offset_limit_out <= 3'h0;
			freq_loop_gain_out <= 4'h4;
			freq_loop_update_en_out <= 1'b0;
		end
		else
		begin
			coarse_rate_scale_out <= coarse_code;
			fine_rate_scale_out <= fine_code;
			low_delay_buffer_select_out <= rate_cfg[DTA_LOW_DELAY_BUFFER_SELECT_POS];
			post_filter_wide_out <= rate_cfg[DTA_LD_BW_POS];
			threshold_lower_bound_out <= $signed(ask_threshold_lower_bound);
			threshold_discharge_double_out <= next_disch_double;
			threshold_time_constant_out <= ask_threshold_discharge_timeconst[DTA_TC_LSB +: 5];
			precharged_lowpass_en_out <= ~method_peak;
			threshold_filter_bw_double_out <= next_bw_double;
			adaptive_peak_detector_en_out <= method_peak;
			threshold_gain_param_out <= ask_threshold_method_gain[DTA_GC_LSB +: 5];
			freq_correction_en_out <= next_corr_en;
			freq_offset_limit_out <= limit_code;
			freq_loop_gain_out <= next_gain;
			freq_loop_update_en_out <= next_update_en;
		end
	end

	// ----------------------------------------------------------------
	// sample enable from the rate converter settings
	// ----------------------------------------------------------------
	dta_rate_gen u_rate_gen (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.coarse_rate_scale_in(coarse_code),
		.fine_rate_scale_in(fine_code),
		.sample_en_out(sample_en_out)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_lower_bound_signed: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(reg_wr_in && hit_lower) |=> ##1 (threshold_lower_bound_out == $signed($past(reg_wdata_in, 2))))
		else $error("lower bound output does not follow written value");
	a_discharge_double: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(reg_wr_in && hit_disch) |=> ##1 (threshold_discharge_double_out == ($past(reg_wdata_in[6:5], 2) == 2'h1)))
		else $error("discharge double does not match code 1");
	a_method_peak: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		method_peak |=> (adaptive_peak_detector_en_out && !precharged_lowpass_en_out && !threshold_filter_bw_double_out))
		else $error("peak method not selected from method bit");
	a_method_lowpass_bw: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(!method_peak && bw_bit) |=> (precharged_lowpass_en_out && threshold_filter_bw_double_out))
		else $error("lowpass bandwidth doubling missing");
	a_limit_disable: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(limit_code == 3'h0) |=> (!freq_correction_en_out && !freq_loop_update_en_out))
		else $error("correction active with limit code 0");
	a_gain_double: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(gain_code == 2'h3) |=> (freq_loop_gain_out == 4'h8 && $past(gain_code) == 2'h3))
		else $error("loop gain code 3 is not double default");
	a_gain_quarter: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(gain_code == 2'h0) |=> freq_loop_gain_out == 4'h1)
		else $error("loop gain code 0 is not quarter default");
	a_freeze_fsk: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(freeze_bit && fsk_mode_in && preamble_detected_in) |=> !freq_loop_update_en_out)
		else $error("correction loop not frozen after preamble");
	a_freeze_ask_ignored: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(!fsk_mode_in && next_corr_en) |=> freq_loop_update_en_out)
		else $error("freeze acted in ASK mode");
	a_unused_zero: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(reg_rd_in && hit_afc) |=> (reg_rdata_out[7:5] == 3'h0))
		else $error("unused bits of correction register read nonzero");
	a_unmapped_zero: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(reg_rd_in && reg_addr_in > DTA_OFS_FREEZE) |=> (reg_rdata_out == 8'h00))
		else $error("unmapped offset read nonzero");

endmodule : dta_demod_cfg

/* tb/dta_host_model.sv */
// host model: byte writes and reads on the register port
// assumes the port samples its strobes on the rising edge of mclk_in
`timescale 1ns/1ps
module dta_host_model
(
	input wire logic mclk_in,
	input wire logic [7:0] reg_rdata_in,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	initial
	begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end

	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk_in);
		#1;
		reg_addr_out = addr;
		reg_wdata_out = data;
		reg_wr_out = 1'b1;
		@(posedge mclk_in);
		#1;
		reg_wr_out = 1'b0;
		// stale data not left on the bus
		reg_wdata_out = ~data;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk_in);
		#1;
		reg_addr_out = addr;
		reg_rd_out = 1'b1;
		@(posedge mclk_in);
		#1;
		data = reg_rdata_in;
		reg_rd_out = 1'b0;
		reg_addr_out = ~addr;
	endtask : read_reg
endmodule : dta_host_model

/* tb/testbench.sv */
// self-checking bench for the demodulator configuration registers
// assumes dta_host_model drives the register port
`timescale 1ns/1ps
module testbench;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic fsk_mode = 1'b0;
	logic preamble_seen = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, sample_en, low_delay_buffer_select, pf_wide, disch_dbl, lpf_en, bw_dbl, apd_en, afc_en, upd_en;
	logic [2:0] coarse, fine, limit;
	logic signed [7:0] lower;
	logic [4:0] tc, gc;
	logic [3:0] gain;
	logic [7:0] shadow [0:15];
	int fail_count = 0;
	int checks = 0;

	initial
	begin
		forever #5 mclk_in = ~mclk_in;
	end

	dta_host_model host (.mclk_in(mclk_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

	dta_demod_cfg dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .fsk_mode_in(fsk_mode), .preamble_detected_in(preamble_seen),
		.reg_rdata_out(reg_rdata), .sample_en_out(sample_en), .coarse_rate_scale_out(coarse),
		.fine_rate_scale_out(fine), .low_delay_buffer_select_out(low_delay_buffer_select), .post_filter_wide_out(pf_wide),
		.threshold_lower_bound_out(lower), .threshold_discharge_double_out(disch_dbl),
		.threshold_time_constant_out(tc), .precharged_lowpass_en_out(lpf_en),
		.threshold_filter_bw_double_out(bw_dbl), .adaptive_peak_detector_en_out(apd_en),
		.threshold_gain_param_out(gc), .freq_correction_en_out(afc_en), .freq_offset_limit_out(limit),
		.freq_loop_gain_out(gain), .freq_loop_update_en_out(upd_en));

	// ----------------------------------------------------------------
	// compares and expectations
	// ----------------------------------------------------------------
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: %s read %h expected %h", $time, what, got, exp);
		end
	endtask : check_byte

	task automatic check_field(input logic [11:0] got, input logic [11:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_field

	function automatic logic [7:0] impl_mask(input logic [7:0] a);
		case (a)
			8'h03, 8'h04: return 8'hFF;
			8'h05, 8'h06: return 8'h7F;
			8'h07: return 8'h1F;
			8'h08: return 8'h40;
			default: return 8'h00;
		endcase
	endfunction : impl_mask

	function automatic logic legal_low_delay(input logic [2:0] c, input logic [2:0] f);
		return (c >= 3'h3) || (c == 3'h2 && !f[0]);
	endfunction : legal_low_delay

	task automatic check_decode();
		check_field(coarse, shadow[3][5:3], "coarse code");
		check_field(fine, shadow[3][2:0], "fine code");
		check_field({low_delay_buffer_select, pf_wide}, shadow[3][7:6], "rate flags");
		check_field(lower, $signed(shadow[4]), "lower bound");
		check_field({disch_dbl, tc}, {shadow[5][6:5] == 2'h1, shadow[5][4:0]}, "discharge");
		check_field({lpf_en, apd_en, bw_dbl, gc},
			{~shadow[6][6], shadow[6][6], shadow[6][5] & ~shadow[6][6], shadow[6][4:0]}, "method");
		check_field({afc_en, limit}, {shadow[7][4:2] != 3'h0, shadow[7][4:2]}, "offset limit");
		check_field(gain, 4'h1 << shadow[7][1:0], "loop gain");
		check_field(upd_en, (shadow[7][4:2] != 3'h0) & ~(shadow[8][6] & fsk_mode & preamble_seen),
			"loop update");
	endtask : check_decode

	task automatic verify_all();
		logic [7:0] got;
		for (int a = 2; a < 10; a++)
		begin
			host.read_reg(8'(a), got);
			check_byte(got, shadow[a], "register");
		end
		check_decode();
	endtask : verify_all

	task automatic wait_pulse(output int n);
		n = 0;
		do
		begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		while (sample_en !== 1'b1 && n < 4000);
	endtask : wait_pulse

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	task automatic test_reset();
		foreach (shadow[i])
			shadow[i] = 8'h00;
		shadow[3] = 8'h10;
		shadow[6] = 8'h0F;
		shadow[7] = 8'h02;
		verify_all();
		$display("test reset values done");
	endtask : test_reset

	task automatic test_random();
		logic [7:0] a;
		logic [7:0] d;
		for (int i = 0; i < 128; i++)
		begin
			a = 8'(2 + i % 8);
			d = 8'($urandom);
			d[5:2] = 4'(i / 8);
			if (a == 8'h03 && !legal_low_delay(d[5:3], d[2:0]))
				d[7] = 1'b0;
			{fsk_mode, preamble_seen} = 2'($urandom);
			host.write_reg(a, d);
			shadow[a] = d & impl_mask(a);
			verify_all();
		end
		$display("test random registers done");
	endtask : test_random

	task automatic test_rate();
		logic [2:0] f;
		int n;
		for (int c = 0; c < 8; c++)
		begin
			// corners: fine 7 at default coarse, fine 0 at both coarse ends
			f = (c == 2) ? 3'h7 : (c == 0 || c == 7) ? 3'h0 : 3'($urandom);
			shadow[3] = {2'b00, 3'(c), f};
			host.write_reg(8'h03, shadow[3]);
			// time constant follows coarse code, longer discharge at slow rates
			shadow[5] = {1'b0, (c > 2) ? 2'h1 : 2'h0, 5'(c)};
			host.write_reg(8'h05, shadow[5]);
			repeat (4) wait_pulse(n);
			check_field(12'(n), 12'((8 + f) << c), "sample period");
			check_decode();
		end
		$display("test rate converter done");
	endtask : test_rate

	task automatic test_freeze();
		shadow[7] = 8'h1F;
		shadow[8] = 8'h40;
		host.write_reg(8'h07, 8'h1F);
		host.write_reg(8'h08, 8'h40);
		fsk_mode = 1'b1;
		preamble_seen = 1'b1;
		repeat (3) @(posedge mclk_in);
		#1;
		check_field(upd_en, 1'b0, "frozen loop");
		// freeze has no effect in ask mode
		fsk_mode = 1'b0;
		repeat (3) @(posedge mclk_in);
		#1;
		check_field(upd_en, 1'b1, "ask loop");
		shadow[7] = 8'h03;
		host.write_reg(8'h07, 8'h03);
		verify_all();
		$display("test freeze done");
	endtask : test_freeze

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		void'($urandom(32'h96cf_35d7));
		repeat (5) @(posedge mclk_in);
		#1;
		rstn_in = 1'b1;
		test_reset();
		test_random();
		test_rate();
		test_freeze();
		tally_and_finish();
	end

	// tests need about 14k cycles, watchdog allows 60k
	initial
	begin
		#600_000;
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule : testbench
